/* File: bus_area_cfg_pkg.sv */
`default_nettype none
package bus_area_cfg_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [15:0] IDX_AREA_WIDTH = 16'hffec;
    localparam logic [15:0] IDX_ACCESS_STATES = 16'hffed;
    localparam logic [15:0] IDX_WAIT_CONTROL = 16'hffee;
    localparam logic [15:0] IDX_WAIT_ENABLE = 16'hffef;
    localparam logic [15:0] IDX_BUS_RELEASE = 16'hfff3;
    localparam int ADDR_W = 18;
    localparam logic [17:0] ADDR_AREA_WIDTH = {IDX_AREA_WIDTH, 2'h0};
    localparam logic [17:0] ADDR_ACCESS_STATES = {IDX_ACCESS_STATES, 2'h0};
    localparam logic [17:0] ADDR_WAIT_CONTROL = {IDX_WAIT_CONTROL, 2'h0};
    localparam logic [17:0] ADDR_WAIT_ENABLE = {IDX_WAIT_ENABLE, 2'h0};
    localparam logic [17:0] ADDR_BUS_RELEASE = {IDX_BUS_RELEASE, 2'h0};
    // Register select codes
    localparam logic [2:0] SEL_WIDTH = 3'h0;
    localparam logic [2:0] SEL_STATES = 3'h1;
    localparam logic [2:0] SEL_WAIT = 3'h2;
    localparam logic [2:0] SEL_WAIT_EN = 3'h3;
    localparam logic [2:0] SEL_RELEASE = 3'h4;
    localparam logic [2:0] SEL_NONE = 3'h7;
    // Reset values
    localparam logic [7:0] RST_AREA_WIDTH_8BIT = 8'hff;
    localparam logic [7:0] RST_AREA_WIDTH_16BIT = 8'h00;
    localparam logic [7:0] RST_ACCESS_STATES = 8'hff;
    localparam logic [7:0] RST_WAIT_CONTROL = 8'hf3;
    localparam logic [7:0] RST_WAIT_ENABLE = 8'hff;
    localparam logic [7:0] RST_BUS_RELEASE = 8'hfe;
    // Field positions and reserved masks
    localparam int WC_MODE_LSB = 2;
    localparam int WC_COUNT_LSB = 0;
    localparam int BR_ADDR_LSB = 5;
    localparam int BR_RELEASE_POS = 0;
    localparam logic [7:0] WC_RSVD_MASK = 8'hf0;
    localparam logic [7:0] BR_RSVD_MASK = 8'h1e;
    // Operating mode pin codes, modes 1 to 4
    localparam logic [1:0] OP_MODE1 = 2'h0;
    localparam logic [1:0] OP_MODE2 = 2'h1;
    localparam logic [1:0] OP_MODE3 = 2'h2;
    localparam logic [1:0] OP_MODE4 = 2'h3;
    // Wait mode field codes
    localparam logic [1:0] WMODE_PROG = 2'h0;
    localparam logic [1:0] WMODE_NONE = 2'h1;
    localparam logic [1:0] WMODE_PIN1 = 2'h2;
    localparam logic [1:0] WMODE_AUTO = 2'h3;
    // Wait behaviour of one access
    localparam logic [2:0] WAIT_KIND_OFF = 3'h0;
    localparam logic [2:0] WAIT_KIND_PROG = 3'h1;
    localparam logic [2:0] WAIT_KIND_PIN0 = 3'h2;
    localparam logic [2:0] WAIT_KIND_PIN1 = 3'h3;
    localparam logic [2:0] WAIT_KIND_AUTO = 3'h4;
    // On-chip targets: fixed 16-bit, two states, no waits
    localparam logic ONCHIP_IS_8BIT = 1'b0;
    localparam logic ONCHIP_IS_3STATE = 1'b0;
    // Cycles spent loading mode-dependent reset values
    localparam logic [2:0] INIT_CYCLES = 3'h5;

    typedef enum logic [2:0] {
        ST_INIT = 3'b001,
        ST_IDLE = 3'b010,
        ST_RESP = 3'b100
    } apb_state_type;

    typedef struct packed {
        logic [7:0] width8;
        logic [7:0] states3;
        logic [7:0] wait_en;
        logic [1:0] wait_mode;
        logic [1:0] wait_count;
    } cfg_type;

    typedef struct packed {
        logic is_8bit;
        logic is_3state;
        logic [2:0] wait_kind;
        logic [1:0] wait_states;
    } spec_type;
endpackage
`default_nettype wire

/* File: area_spec_lookup.sv */
`timescale 1ns/1ps
`default_nettype none
module area_spec_lookup (
    // Configuration and access
    input wire bus_area_cfg_pkg::cfg_type i_cfg,
    input wire logic [2:0] i_area,
    input wire logic i_external,
    // Resulting bus specification
    output var bus_area_cfg_pkg::spec_type o_spec
);
    import bus_area_cfg_pkg::*;

    always_comb begin
        o_spec = '0;
        // RULE_06: on-chip fixed width
        // RULE_08: on-chip fixed states
        if (!i_external) begin
            o_spec.is_8bit = ONCHIP_IS_8BIT;
            o_spec.is_3state = ONCHIP_IS_3STATE;
            o_spec.wait_kind = WAIT_KIND_OFF;
        end else begin
            // RULE_20: addressed area's bits
            // RULE_05: width per area
            o_spec.is_8bit = i_cfg.width8[i_area];
            // RULE_07: two or three states
            o_spec.is_3state = i_cfg.states3[i_area];
            if (!i_cfg.states3[i_area]) begin
                o_spec.wait_kind = WAIT_KIND_OFF;
            // RULE_13: disabled means pin mode 0
            end else if (!i_cfg.wait_en[i_area]) begin
                o_spec.wait_kind = WAIT_KIND_PIN0;
            end else begin
                // RULE_10: wait mode decode
                case (i_cfg.wait_mode)
                    WMODE_PROG: o_spec.wait_kind = WAIT_KIND_PROG;
                    WMODE_NONE: o_spec.wait_kind = WAIT_KIND_OFF;
                    WMODE_PIN1: o_spec.wait_kind = WAIT_KIND_PIN1;
                    default: o_spec.wait_kind = WAIT_KIND_AUTO;
                endcase
                // RULE_11: inserted wait count
                if (i_cfg.wait_mode != WMODE_NONE) begin
                    o_spec.wait_states = i_cfg.wait_count;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: bus_area_config.sv */
// Notes on behaviour
// RULE_01: All width bits one gives 8-bit bus
// RULE_02: Any width bit zero gives 16-bit bus
// RULE_03: Width reset value follows operating mode
// RULE_04: Software standby keeps all registers
// RULE_05: Width bit zero 16-bit, one 8-bit
// RULE_06: On-chip targets keep fixed width
// RULE_07: State bit zero two, one three; reset ones
// RULE_08: On-chip targets keep fixed state count
// RULE_09: Reserved bits ignore writes, read one
// RULE_10: Wait mode field decode, reset programmable
// RULE_11: Wait count zero to three, reset three
// RULE_12: Wait control resets to f3
// RULE_13: Wait enable zero gives pin mode 0
// RULE_14: Bus release control resets to fe
// RULE_15: Address enable zero drives upper address
// RULE_16: Address enables locked outside modes 3, 4
// RULE_17: Release enable gates bus release
// RULE_18: External master waits for acknowledge
// RULE_19: Slow device stretches with wait input
// RULE_20: Eight areas, addressed area's bits apply
// RULE_21: Five byte registers, read back stored
`timescale 1ns/1ps
`default_nettype none
module bus_area_config (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [17:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    // Mode and standby pins
    input wire logic [1:0] i_op_mode,
    input wire logic i_hw_standby,
    // Access being started by the bus cycle logic
    input wire logic [2:0] i_acc_area,
    input wire logic i_acc_external,
    // Configuration outputs
    output bus_area_cfg_pkg::cfg_type o_cfg,
    output bus_area_cfg_pkg::spec_type o_acc_spec,
    output logic o_bus_8bit_mode,
    output logic [2:0] o_addr_out_en,
    output logic o_bus_release_en
);
    import bus_area_cfg_pkg::*;

    function automatic logic [2:0] reg_sel(input logic [17:0] addr);
        if (addr == ADDR_AREA_WIDTH) begin
            return SEL_WIDTH;
        end else if (addr == ADDR_ACCESS_STATES) begin
            return SEL_STATES;
        end else if (addr == ADDR_WAIT_CONTROL) begin
            return SEL_WAIT;
        end else if (addr == ADDR_WAIT_ENABLE) begin
            return SEL_WAIT_EN;
        end else if (addr == ADDR_BUS_RELEASE) begin
            return SEL_RELEASE;
        end else begin
            return SEL_NONE;
        end
    endfunction

    apb_state_type state_q;
    logic [2:0] init_cnt_q;
    logic [1:0] mode_s1, mode_s2, mode_s3, mode_q;
    logic stby_s1, stby_s2, stby_s3, stby_q;
    logic [7:0] abw_q, ast_q, wce_q;
    logic [1:0] wmode_q, wcount_q;
    logic [2:0] addr_en_q;
    logic bus_release_enable_q;
    logic [2:0] sel;
    logic mode34, mode13, wr_en;
    logic [7:0] rd_byte;
    cfg_type cfg;
    spec_type spec;

    // Pins pass three flops; a change counts once the last two agree
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            mode_s1 <= OP_MODE1;
            mode_s2 <= OP_MODE1;
            mode_s3 <= OP_MODE1;
            mode_q <= OP_MODE1;
            stby_s1 <= 1'b0;
            stby_s2 <= 1'b0;
            stby_s3 <= 1'b0;
            stby_q <= 1'b0;
        end else begin
            mode_s1 <= i_op_mode;
            mode_s2 <= mode_s1;
            mode_s3 <= mode_s2;
            if (mode_s2 == mode_s3) begin
                mode_q <= mode_s3;
            end
            stby_s1 <= i_hw_standby;
            stby_s2 <= stby_s1;
            stby_s3 <= stby_s2;
            if (stby_s2 == stby_s3) begin
                stby_q <= stby_s3;
            end
        end
    end

    assign mode34 = (mode_q == OP_MODE3) || (mode_q == OP_MODE4);
    assign mode13 = (mode_q == OP_MODE1) || (mode_q == OP_MODE3);
    assign sel = reg_sel(i_paddr);
    assign wr_en = (state_q == ST_RESP) && i_psel && i_penable && i_pwrite
                   && (sel != SEL_NONE) && !stby_q;

    // Bus is held off while mode-dependent values settle
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= ST_INIT;
            init_cnt_q <= INIT_CYCLES;
        end else if (stby_q) begin
            state_q <= ST_INIT;
            init_cnt_q <= INIT_CYCLES;
        end else begin
            case (state_q)
                ST_INIT: begin
                    init_cnt_q <= init_cnt_q - 3'h1;
                    if (init_cnt_q == 3'h1) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (i_psel && i_penable) begin
                        state_q <= ST_RESP;
                    end
                end
                ST_RESP: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_INIT;
                end
            endcase
        end
    end

    // Width bits: reset value comes from the mode straps after release
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            abw_q <= RST_AREA_WIDTH_8BIT;
        // RULE_03: mode-dependent load
        // RULE_04: only reset or standby reload
        end else if (stby_q || state_q == ST_INIT) begin
            abw_q <= mode13 ? RST_AREA_WIDTH_8BIT : RST_AREA_WIDTH_16BIT;
        end else if (wr_en && sel == SEL_WIDTH) begin
            abw_q <= i_pwdata[7:0];
        end
    end

    // State count and wait enable bits
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            ast_q <= RST_ACCESS_STATES;
            wce_q <= RST_WAIT_ENABLE;
        // RULE_07: states reset to ones
        // RULE_13: enables reset to ones
        end else if (stby_q) begin
            ast_q <= RST_ACCESS_STATES;
            wce_q <= RST_WAIT_ENABLE;
        end else if (wr_en && sel == SEL_STATES) begin
            ast_q <= i_pwdata[7:0];
        end else if (wr_en && sel == SEL_WAIT_EN) begin
            wce_q <= i_pwdata[7:0];
        end
    end

    // Wait control; the reserved upper nibble is not stored at all
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            wmode_q <= RST_WAIT_CONTROL[WC_MODE_LSB+:2];
            wcount_q <= RST_WAIT_CONTROL[WC_COUNT_LSB+:2];
        // RULE_12: reload f3
        end else if (stby_q) begin
            wmode_q <= RST_WAIT_CONTROL[WC_MODE_LSB+:2];
            wcount_q <= RST_WAIT_CONTROL[WC_COUNT_LSB+:2];
        end else if (wr_en && sel == SEL_WAIT) begin
            wmode_q <= i_pwdata[WC_MODE_LSB+:2];
            wcount_q <= i_pwdata[WC_COUNT_LSB+:2];
        end
    end

    // Bus release control
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            addr_en_q <= RST_BUS_RELEASE[BR_ADDR_LSB+:3];
            bus_release_enable_q <= RST_BUS_RELEASE[BR_RELEASE_POS];
        // RULE_14: reload fe
        end else if (stby_q) begin
            addr_en_q <= RST_BUS_RELEASE[BR_ADDR_LSB+:3];
            bus_release_enable_q <= RST_BUS_RELEASE[BR_RELEASE_POS];
        end else if (wr_en && sel == SEL_RELEASE) begin
            // RULE_16: address enables locked
            if (mode34) begin
                addr_en_q <= i_pwdata[BR_ADDR_LSB+:3];
            end
            bus_release_enable_q <= i_pwdata[BR_RELEASE_POS];
        end
    end

    // RULE_21: stored value read back
    // RULE_09: reserved bits read one
    always_comb begin
        rd_byte = 8'h00;
        if (sel == SEL_WIDTH) begin
            rd_byte = abw_q;
        end else if (sel == SEL_STATES) begin
            rd_byte = ast_q;
        end else if (sel == SEL_WAIT) begin
            rd_byte = WC_RSVD_MASK | {4'h0, wmode_q, wcount_q};
        end else if (sel == SEL_WAIT_EN) begin
            rd_byte = wce_q;
        end else if (sel == SEL_RELEASE) begin
            rd_byte = BR_RSVD_MASK | {addr_en_q, 4'h0, bus_release_enable_q};
        end
    end

    // One wait cycle in the access phase keeps pready a plain flop
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else if (state_q == ST_IDLE && i_psel && i_penable && !stby_q) begin
            o_pready <= 1'b1;
            o_prdata <= i_pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            o_pslverr <= (sel == SEL_NONE);
        end else begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end
    end

    assign cfg.width8 = abw_q;
    assign cfg.states3 = ast_q;
    assign cfg.wait_en = wce_q;
    assign cfg.wait_mode = wmode_q;
    assign cfg.wait_count = wcount_q;

    area_spec_lookup u_lookup (
        .i_cfg(cfg),
        .i_area(i_acc_area),
        .i_external(i_acc_external),
        .o_spec(spec)
    );

    // Configuration outputs
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_cfg <= '0;
            o_acc_spec <= '0;
            o_bus_8bit_mode <= 1'b0;
            o_addr_out_en <= 3'h0;
            o_bus_release_en <= 1'b0;
        end else begin
            o_cfg <= cfg;
            o_acc_spec <= spec;
            // RULE_01: all ones is 8-bit bus
            // RULE_02: any zero is 16-bit bus
            o_bus_8bit_mode <= &abw_q;
            // RULE_15: zero drives address pin
            o_addr_out_en <= mode34 ? ~addr_en_q : 3'h0;
            // RULE_17: release only when enabled
            o_bus_release_en <= bus_release_enable_q;
        end
    end

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_nrst);

    sequence seq_access_start;
        state_q == ST_IDLE && i_psel && i_penable && !stby_q;
    endsequence

    sequence seq_release_write_locked;
        wr_en && sel == SEL_RELEASE && !mode34;
    endsequence

    sequence seq_init_last;
        state_q == ST_INIT && init_cnt_q == 3'h1 && !stby_q;
    endsequence

    AST_BUS_8BIT: assert property ( // RULE_01
        (&abw_q) |=> o_bus_8bit_mode)
        else $error("8-bit bus mode not shown");

    AST_BUS_16BIT: assert property ( // RULE_02
        !(&abw_q) |=> !o_bus_8bit_mode)
        else $error("16-bit bus mode not shown");

    AST_WIDTH_INIT: assert property ( // RULE_03
        seq_init_last |=> (abw_q == ($past(mode13) ? 8'hff : 8'h00)))
        else $error("width reset value wrong for mode");

    AST_KEEP_IDLE: assert property ( // RULE_04
        state_q == ST_IDLE && !stby_q |=> $stable(cfg) && $stable(addr_en_q))
        else $error("configuration changed without a write");

    AST_RSVD_WAIT: assert property ( // RULE_09
        seq_access_start and (!i_pwrite && sel == SEL_WAIT)
        |=> o_pready && o_prdata[7:4] == 4'hf)
        else $error("reserved wait bits not read as one");

    AST_ONCHIP_FIXED: assert property ( // RULE_06
        !i_acc_external |=> !o_acc_spec.is_8bit && !o_acc_spec.is_3state
        && o_acc_spec.wait_kind == WAIT_KIND_OFF)
        else $error("on-chip access took area settings");

    AST_AREA_WIDTH: assert property ( // RULE_05
        i_acc_external |=> o_acc_spec.is_8bit == $past(abw_q[i_acc_area]))
        else $error("area width not applied");

    AST_AREA_STATES: assert property ( // RULE_07
        i_acc_external |=> o_acc_spec.is_3state == $past(ast_q[i_acc_area]))
        else $error("area state count not applied");

    AST_ADDR_LOCK: assert property ( // RULE_16
        seq_release_write_locked |=> $stable(addr_en_q) && o_addr_out_en == 3'h0)
        else $error("address enable changed outside modes 3 and 4");

    AST_RELEASE: assert property ( // RULE_17
        ##1 o_bus_release_en == $past(bus_release_enable_q))
        else $error("release enable does not follow register");

    AST_APB_ANSWER: assert property ( // RULE_21
        seq_access_start |=> o_pready ##1 !o_pready)
        else $error("APB answer not a single pulse after one wait");

    AST_RSVD_RELEASE: assert property ( // RULE_09
        seq_access_start and (!i_pwrite && sel == SEL_RELEASE)
        |=> o_pready && o_prdata[4:1] == 4'hf)
        else $error("reserved release bits not read as one");

    AST_UNMAPPED: assert property ( // RULE_21
        seq_access_start and (sel == SEL_NONE)
        |=> o_pready && o_pslverr && o_prdata == 32'h0000_0000)
        else $error("unmapped access not refused");

    AST_STBY_RELEASE: assert property ( // RULE_14
        stby_q |=> addr_en_q == RST_BUS_RELEASE[BR_ADDR_LSB+:3]
        && bus_release_enable_q == RST_BUS_RELEASE[BR_RELEASE_POS])
        else $error("release control not reloaded in standby");

    AST_STBY_WAIT: assert property ( // RULE_12
        stby_q |=> wmode_q == RST_WAIT_CONTROL[WC_MODE_LSB+:2]
        && wcount_q == RST_WAIT_CONTROL[WC_COUNT_LSB+:2])
        else $error("wait control not reloaded in standby");
endmodule
`default_nettype wire

/* File: bus_access_source.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_access_source (
    // Clock, reset and run control
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_run,
    // Answers from the configuration block
    input wire logic i_release_en,
    input wire logic i_3state,
    // Access seen by the configuration block
    output logic [2:0] o_area,
    output logic o_external,
    // External master and slow device
    output logic o_bus_req,
    output logic o_bus_take,
    output logic o_wait_req
);
    integer seed = 11;
    always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_area <= 3'h0;
            o_external <= 1'b0;
            o_bus_req <= 1'b0;
            o_bus_take <= 1'b0;
            o_wait_req <= 1'b0;
        end else if (i_run) begin
            o_area <= 3'($random(seed));
            o_external <= 1'($random(seed));
            o_bus_req <= 1'($random(seed));
            o_bus_take <= o_bus_req && i_release_en;
            o_wait_req <= i_3state && 1'($random(seed));
        end else begin
            o_bus_req <= 1'b0;
            o_bus_take <= 1'b0;
            o_wait_req <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import bus_area_cfg_pkg::*;
    localparam logic [17:0] UNMAPPED = 18'h3ffc0;
    logic i_mclk = 1'b0, i_nrst = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [17:0] i_paddr = 18'h0;
    logic [31:0] i_pwdata = 32'h0;
    logic [1:0] i_op_mode = OP_MODE1;
    logic i_hw_standby = 1'b0, run = 1'b0, pend = 1'b0;
    logic o_pready, o_pslverr, o_bus_8bit_mode, o_bus_release_en, acc_ext;
    logic [31:0] o_prdata;
    logic [2:0] o_addr_out_en, acc_area;
    cfg_type o_cfg;
    spec_type o_acc_spec;
    logic [32:0] aq[$], note;
    spec_type sq[$];
    logic [7:0] w_m, st_m, we_m, br_m;
    logic [1:0] wm_m, wc_m, cur_md;
    logic [17:0] addrs[5] = '{ADDR_AREA_WIDTH, ADDR_ACCESS_STATES, ADDR_WAIT_CONTROL,
                               ADDR_WAIT_ENABLE, ADDR_BUS_RELEASE};
    integer num_errors = 0, checks_done = 0, seed = 11;
    logic [31:0] r;

    always #12.5 i_mclk = ~i_mclk;

    bus_area_config bus_area_config_i (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_op_mode(i_op_mode),
        .i_hw_standby(i_hw_standby), .i_acc_area(acc_area), .i_acc_external(acc_ext),
        .o_cfg(o_cfg), .o_acc_spec(o_acc_spec), .o_bus_8bit_mode(o_bus_8bit_mode),
        .o_addr_out_en(o_addr_out_en), .o_bus_release_en(o_bus_release_en));
    bus_access_source bus_access_source_i (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_run(run),
        .i_release_en(o_bus_release_en), .i_3state(o_acc_spec.is_3state), .o_area(acc_area),
        .o_external(acc_ext), .o_bus_req(), .o_bus_take(), .o_wait_req());

    task automatic cmp_word(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cmp_spec(input spec_type e, input spec_type g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH acc_spec expected %h seen %h", e, g);
        end
    endtask

    function automatic logic m34();
        return cur_md == OP_MODE3 || cur_md == OP_MODE4;
    endfunction

    // Register read value from the model
    function automatic logic [31:0] rdv(input logic [17:0] a);
        case (a)
            ADDR_AREA_WIDTH: return {24'h0, w_m};
            ADDR_ACCESS_STATES: return {24'h0, st_m};
            ADDR_WAIT_CONTROL: return {24'h0, 4'hf, wm_m, wc_m};
            ADDR_WAIT_ENABLE: return {24'h0, we_m};
            default: return {24'h0, br_m};
        endcase
    endfunction

    // Bus specification the addressed area should get
    function automatic spec_type exp_spec(input logic [2:0] a, input logic e);
        spec_type s;
        s = '0;
        s.is_8bit = e ? w_m[a] : ONCHIP_IS_8BIT;
        s.is_3state = e ? st_m[a] : ONCHIP_IS_3STATE;
        if (e && st_m[a]) begin
            if (!we_m[a]) begin
                s.wait_kind = WAIT_KIND_PIN0;
            end else begin
                case (wm_m)
                    WMODE_PROG: s.wait_kind = WAIT_KIND_PROG;
                    WMODE_NONE: s.wait_kind = WAIT_KIND_OFF;
                    WMODE_PIN1: s.wait_kind = WAIT_KIND_PIN1;
                    default: s.wait_kind = WAIT_KIND_AUTO;
                endcase
                if (wm_m != WMODE_NONE) s.wait_states = wc_m;
            end
        end
        return s;
    endfunction

    task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic err);
        int k;
        aq.push_back({err, w ? 32'h0 : e});
        @(posedge i_mclk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        k = 0;
        do begin
            @(posedge i_mclk);
            k++;
        end while (o_pready !== 1'b1 && k < 30);
        if (k >= 30) cmp_word("pready", 32'h1, 32'h0);
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic put(input logic [17:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
        case (a)
            ADDR_AREA_WIDTH: w_m = d[7:0];
            ADDR_ACCESS_STATES: st_m = d[7:0];
            ADDR_WAIT_ENABLE: we_m = d[7:0];
            ADDR_WAIT_CONTROL: {wm_m, wc_m} = d[3:0];
            default: begin
                if (m34()) br_m[7:5] = d[7:5];
                br_m[0] = d[0];
            end
        endcase
        apb(1'b0, a, 32'h0, rdv(a), 1'b0);
    endtask

    task automatic read_all();
        for (int i = 0; i < 5; i++) apb(1'b0, addrs[i], 32'h0, rdv(addrs[i]), 1'b0);
    endtask

    task automatic levels();
        repeat (3) @(posedge i_mclk);
        cmp_word("bus_8bit", 32'(w_m == 8'hff), 32'(o_bus_8bit_mode));
        cmp_word("addr_out_en", 32'(m34() ? 3'(~br_m[7:5]) : 3'h0), 32'(o_addr_out_en));
        cmp_word("release_en", 32'(br_m[0]), 32'(o_bus_release_en));
        cmp_word("cfg", 32'({w_m, st_m, we_m, wm_m, wc_m}), 32'(o_cfg));
    endtask

    task automatic reset_model();
        w_m = (cur_md == OP_MODE1 || cur_md == OP_MODE3) ? 8'hff : 8'h00;
        {st_m, we_m, br_m} = {8'hff, 8'hff, 8'hfe};
        {wm_m, wc_m} = 4'h3;
    endtask

    task automatic conclude();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // APB answers against the oldest note
    always @(posedge i_mclk) begin
        if (o_pready === 1'b1) begin
            note = aq.size() > 0 ? aq.pop_front() : 33'h1ffffffff;
            cmp_word("prdata", note[31:0], o_prdata);
            cmp_word("pslverr", 32'(note[32]), 32'(o_pslverr));
        end
    end

    // Notes for each access the partner presents
    always @(posedge i_mclk) begin
        if (run) sq.push_back(exp_spec(acc_area, acc_ext));
        pend <= run;
    end

    always @(posedge i_mclk) begin
        if (pend && sq.size() > 0) cmp_spec(sq.pop_front(), o_acc_spec);
    end

    initial begin
        #(25 * 20000);
        num_errors++;
        conclude();
    end

    initial begin
        for (int md = 0; md < 4; md++) begin
            @(posedge i_mclk);
            i_op_mode <= 2'(md);
            i_nrst <= 1'b0;
            repeat (3) @(posedge i_mclk);
            i_nrst <= 1'b1;
            repeat (8) @(posedge i_mclk);
            cur_md = 2'(md);
            reset_model();
            read_all();
            levels();
            put(ADDR_BUS_RELEASE, 32'h40 | 32'(md[0]));
            levels();
        end
        // Random settings walk every wait mode, partner probes all areas
        for (int m = 0; m < 4; m++) begin
            r = $random(seed);
            put(ADDR_AREA_WIDTH, m == 3 ? 32'hff : r);
            put(ADDR_ACCESS_STATES, $random(seed));
            put(ADDR_WAIT_ENABLE, $random(seed));
            r = $random(seed);
            put(ADDR_WAIT_CONTROL, {r[31:4], 2'(m), r[1:0]});
            put(ADDR_BUS_RELEASE, $random(seed));
            levels();
            run <= 1'b1;
            repeat (40) @(posedge i_mclk);
            run <= 1'b0;
            repeat (3) @(posedge i_mclk);
        end
        apb(1'b1, UNMAPPED, 32'hff, 32'h0, 1'b1);
        apb(1'b0, UNMAPPED, 32'h0, 32'h0, 1'b1);
        read_all();
        put(ADDR_AREA_WIDTH, 32'h5a);
        i_hw_standby <= 1'b1;
        repeat (8) @(posedge i_mclk);
        i_hw_standby <= 1'b0;
        repeat (15) @(posedge i_mclk);
        reset_model();
        read_all();
        levels();
        conclude();
    end
endmodule
`default_nettype wire
